/* File: readback_pkg.sv */
// Notes on behaviour
// - power-on flag reads one, cleared only by reading
// - status select returns chosen output's fault flags
// - flags: overcurrent, short, temperature, supply, openload, voltage, reset
// - fault pin shows faults; latched cleared by toggle
// - codes 001-100 return chosen output's stored settings
// - code 00101 returns global configuration contents
// - code 00111 bit 2 flags bad PWM clock
// - clock/temperature word bit 1 flags calibration failure
// - clock/temperature word bit 0 flags overtemperature prewarning
// - code 01111 returns live inputs and watchdog enable
// - in fail-safe, input word reports output states
// - code 10111 returns fixed product code, low bits
// - reset: outputs follow input or on bit, medium slew
// - reset: xenon profile, protections and retry enabled
// - reset: openload and supply-short detection stay active
// - reset: no mirroring, overvoltage on, supply-fail off
// - after reset return fault status of output 0
// - header: watchdog bit, select echo, normal-mode bit
// - selection persists until next status-select write
package readback_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int         WD_POS       = 15;          // watchdog bit of a frame
  localparam int         CMD_HI       = 14;          // command / select echo field
  localparam int         CMD_LO       = 10;
  localparam int         NM_POS       = 9;           // normal mode bit
  localparam logic [3:0] EDGE_HEADER  = 4'h0;        // link edge that loads the header
  localparam logic [3:0] EDGE_FIELD   = 4'h6;        // link edge that loads the readback
  localparam logic [3:0] EDGE_LAST    = 4'hf;        // last edge of a 16-bit block

  // ****************************************
  // select codes: {output, kind}
  // ****************************************
  localparam logic [2:0] KIND_STATUS  = 3'h0;
  localparam logic [2:0] KIND_PWM     = 3'h1;
  localparam logic [2:0] KIND_CONF0   = 3'h2;
  localparam logic [2:0] KIND_CONF1   = 3'h3;
  localparam logic [2:0] KIND_OCR     = 3'h4;
  localparam logic [4:0] SEL_GLOBAL   = 5'h05;
  localparam logic [4:0] SEL_CLK_TEMP = 5'h07;
  localparam logic [4:0] SEL_IN_WD    = 5'h0f;
  localparam logic [4:0] SEL_PRODUCT  = 5'h17;
  localparam logic [4:0] SEL_RESET    = 5'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int FLT_POR = 8, FLT_UV = 7, FLT_OV = 6, FLT_OLON = 5, FLT_OLOFF = 4;
  localparam int FLT_OS = 3, FLT_OT = 2, FLT_SC = 1, FLT_OC = 0;
  localparam int DG_CLOCK = 2, DG_CAL = 1, DG_OTW = 0;
  localparam int PWM_ON_POS    = 7;
  localparam int CONF0_DIR_DIS = 5;
  localparam int CONF0_SR_LO   = 3;
  localparam int CONF1_RTY_DIS = 5;
  localparam int OCR_XENON     = 8;
  localparam int GCR_VDD_FAIL  = 8;
  localparam int GCR_OV_DIS    = 0;

  // ****************************************
  // stored field masks and reset values
  // ****************************************
  localparam logic [8:0] PWM_MASK    = 9'h0ff;
  localparam logic [8:0] CONF0_MASK  = 9'h03f;
  localparam logic [8:0] CONF1_MASK  = 9'h07f;
  localparam logic [8:0] OCR_MASK    = 9'h1ff;
  localparam logic [8:0] GCR_MASK    = 9'h1fd;
  localparam logic [8:0] PWM_RESET   = 9'h000;
  localparam logic [8:0] CONF0_RESET = 9'h008;   // direct input on, slew 01 = medium
  localparam logic [8:0] CONF1_RESET = 9'h000;   // retry on, all detections on
  localparam logic [8:0] OCR_RESET   = 9'h100;   // xenon profile
  localparam logic [8:0] GCR_RESET   = 9'h000;   // no mirroring, no temp, ov on, vdd-fail off
  localparam logic       POR_RESET   = 1'b1;
  localparam logic [2:0] PRODUCT_ID  = 3'h5;     // value is arbitrary

endpackage

/* File: level_sync.sv */
// two-flop synchroniser for pin levels
module level_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  // first stage is read only by the second stage
  logic [WIDTH-1:0] meta_q;

  // ****************************************
  // two stages
  // ****************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // level_sync

/* File: frame_bit_counter.sv */
// counts link edges in a frame; the frame's own select ends it
module frame_bit_counter (
  input  wire logic       i_sclk,
  input  wire logic       i_reset,
  input  wire logic       i_cs_n,
  output logic      [4:0] o_count   // [3:0] edges mod 16, [4] past first block
);
  // ****************************************
  // counter, cleared while select is high
  // ****************************************
  // no link edge follows the frame, so the clear must be asynchronous
  always_ff @(posedge i_sclk or posedge i_reset or posedge i_cs_n) begin
    if (i_reset || i_cs_n) begin
      o_count <= 5'h00;
    end else begin
      o_count <= {o_count[4] | (o_count[3:0] == 4'hf), o_count[3:0] + 4'h1};
    end
  end
endmodule // frame_bit_counter

/* File: spi_status_readback_mux.sv */
module spi_status_readback_mux
  import readback_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_sclk,                  // link clock
  input  wire logic       i_cs_n,                  // frame select, active low
  input  wire logic       i_si,                    // serial data in
  output logic            o_so,                    // serial data out
  output logic            o_so_oe,                 // high while driving o_so
  input  wire logic [3:0] i_direct_in,             // direct input pins
  input  wire logic       i_normal_mode_flag,
  input  wire logic       i_por_event,             // supply power-on reset seen
  input  wire logic [3:0] i_overcurrent_flag,
  input  wire logic [3:0] i_severe_short_flag,
  input  wire logic [3:0] i_short_to_supply_flag,
  input  wire logic [3:0] i_openload_off_flag,
  input  wire logic [3:0] i_openload_on_flag,
  input  wire logic [3:0] i_overtemp_flag,
  input  wire logic       i_overvoltage_flag,
  input  wire logic       i_undervoltage_flag,
  input  wire logic       i_fault_control,         // toggled by switch-off command
  input  wire logic       i_pwm_clock_fail,
  input  wire logic       i_cal_fail,
  input  wire logic       i_overtemp_prewarning,
  input  wire logic       i_watchdog_enabled_flag,
  input  wire logic       i_failsafe,
  input  wire logic [3:0] i_failsafe_outputs,
  output logic            o_fault_status_pin_n,
  output logic [3:0]      o_high_side_output,
  output logic [7:0]      o_slew_rate,
  output logic [3:0]      o_xenon_profile,
  output logic [3:0]      o_retry_enable,
  output logic            o_overvoltage_protect,
  output logic            o_vdd_fail_detect
);
  import readback_pkg::*;

  // ****************************************
  // state types
  // ****************************************
  typedef struct packed {
    logic [4:0]      sel;      // readback select
    logic            tog_seen; // link frame marker at last frame end
    logic            por;      // power-on flag
    logic [3:0]      latch;    // latched faults per output
    logic            ctl_prev; // fault control last cycle
    logic            cs_prev;  // synced select last cycle
    logic [14:0]     resp;     // next response, bits 14:0
    logic            so_oe;
    logic [3:0][8:0] pwm;
    logic [3:0][8:0] conf0;
    logic [3:0][8:0] conf1;
    logic [3:0][8:0] overcurrent_setting;
    logic [8:0]      global_config;
    logic            fault_n;
    logic [3:0]      hs;
    logic [7:0]      slew;
    logic [3:0]      xenon;
    logic [3:0]      retry;
    logic            ov_prot;
    logic            vdd_fail;
  } sys_state_t;

  typedef struct packed {
    logic [15:0] rx;           // received word
    logic [15:0] tx;           // outgoing shift register
    logic        valid;        // edges so far are a multiple of 16
    logic        frame_tog;    // flips at the first edge of every frame
  } link_state_t;

  sys_state_t  s_q, s_d;       // system clock state
  link_state_t l_q, l_d;       // link clock state
  logic [4:0]  sync_out;       // {select, direct inputs} after sync
  logic        cs_s;           // synced select, high = idle
  logic [3:0]  in_s;           // synced direct inputs
  logic [4:0]  edge_cnt;       // link edges before this one
  logic        accept;         // a whole valid frame just ended
  logic [4:0]  cmd;            // command field of accepted word
  logic [8:0]  data;           // data field of accepted word
  logic [1:0]  out_a;          // output chosen by select
  logic [8:0]  fault_word;     // flags of the chosen output

  // ****************************************
  // crossings
  // ****************************************
  level_sync #(
    .WIDTH     (5),
    .RESET_VAL (5'h10)
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async ({i_cs_n, i_direct_in}),
    .o_sync  (sync_out)
  );
  assign cs_s = sync_out[4];
  assign in_s = sync_out[3:0];

  frame_bit_counter u_count (
    .i_sclk  (i_sclk),
    .i_reset (i_reset),
    .i_cs_n  (i_cs_n),
    .o_count (edge_cnt)
  );

  // rx, valid and the frame marker are still once select is high, so the synced rise
  // qualifies them; an unchanged marker means a frame with no edge, which is refused
  assign accept    = cs_s && !s_q.cs_prev && l_q.valid && (l_q.frame_tog != s_q.tog_seen);
  assign cmd       = l_q.rx[CMD_HI:CMD_LO];
  assign data      = l_q.rx[8:0];
  assign out_a     = s_q.sel[4:3];

  // flags of the chosen output, bit order of the status word
  assign fault_word = {s_q.por, i_undervoltage_flag, i_overvoltage_flag,
                       i_openload_on_flag[out_a], i_openload_off_flag[out_a],
                       i_short_to_supply_flag[out_a], i_overtemp_flag[out_a],
                       i_severe_short_flag[out_a], i_overcurrent_flag[out_a]};

  // ****************************************
  // system clock next state
  // ****************************************
  always_comb begin
    logic [8:0] rb;            // readback field
    logic       toggle;        // fault control changed
    rb     = 9'h000;
    toggle = i_fault_control ^ s_q.ctl_prev;
    s_d    = s_q;
    s_d.cs_prev  = cs_s;
    s_d.ctl_prev = i_fault_control;
    s_d.so_oe    = !cs_s;
    // remember the link's frame marker at every frame end
    if (cs_s && !s_q.cs_prev) begin
      s_d.tog_seen = l_q.frame_tog;
    end

    // power-on flag: set wins over the read that clears it
    if (accept && (s_q.sel[2:0] == KIND_STATUS)) begin
      s_d.por = 1'b0;
    end
    if (i_por_event) begin
      s_d.por = 1'b1;
    end

    // frame commands take effect only on a valid length
    if (accept) begin
      unique case (cmd[2:0])
        KIND_STATUS: begin
          s_d.sel = data[4:0];
        end
        KIND_PWM: begin
          s_d.pwm[cmd[4:3]] = data & PWM_MASK;
        end
        KIND_CONF0: begin
          s_d.conf0[cmd[4:3]] = data & CONF0_MASK;
        end
        KIND_CONF1: begin
          s_d.conf1[cmd[4:3]] = data & CONF1_MASK;
        end
        KIND_OCR: begin
          s_d.overcurrent_setting[cmd[4:3]] = data & OCR_MASK;
        end
        default: begin
          // global write only on its own code; diagnostics are read-only
          if (cmd == SEL_GLOBAL) begin
            s_d.global_config = data & GCR_MASK;
          end
        end
      endcase
    end

    // readback mux
    unique case (s_q.sel[2:0])
      KIND_STATUS: rb = fault_word;
      KIND_PWM:    rb = s_q.pwm[out_a];
      KIND_CONF0:  rb = s_q.conf0[out_a];
      KIND_CONF1:  rb = s_q.conf1[out_a];
      KIND_OCR:    rb = s_q.overcurrent_setting[out_a];
      default: begin
        if (s_q.sel == SEL_GLOBAL) begin
          rb = s_q.global_config;
        end else if (s_q.sel == SEL_CLK_TEMP) begin
          rb[DG_CLOCK] = i_pwm_clock_fail;
          rb[DG_CAL]   = i_cal_fail;
          rb[DG_OTW]   = i_overtemp_prewarning;
        end else if (s_q.sel == SEL_IN_WD) begin
          rb[4:1] = i_failsafe ? i_failsafe_outputs : in_s;
          rb[0]   = i_watchdog_enabled_flag;
        end else if (s_q.sel == SEL_PRODUCT) begin
          rb[2:0] = PRODUCT_ID;
        end else begin
          rb = 9'h000;
        end
      end
    endcase

    // response frozen while a frame runs, so the link reads a still word
    if (cs_s) begin
      s_d.resp = {s_q.sel, i_normal_mode_flag, rb};
    end

    // fault pin: latched faults hold until a new switch-off toggle
    s_d.latch = (s_q.latch & ~{4{toggle}}) | i_overcurrent_flag | i_severe_short_flag
              | i_overtemp_flag;
    s_d.fault_n = !((|s_d.latch) | (|i_openload_off_flag) | (|i_openload_on_flag)
                | (|i_short_to_supply_flag) | i_overvoltage_flag | i_undervoltage_flag);

    // per-output controls from the stored settings
    for (int i = 0; i < 4; i++) begin
      if (i_failsafe) begin
        s_d.hs[i] = i_failsafe_outputs[i];
      end else if (s_q.conf0[i][CONF0_DIR_DIS]) begin
        s_d.hs[i] = s_q.pwm[i][PWM_ON_POS];
      end else begin
        s_d.hs[i] = in_s[i] | s_q.pwm[i][PWM_ON_POS];
      end
      s_d.slew[2*i +: 2] = s_q.conf0[i][CONF0_SR_LO +: 2];
      s_d.xenon[i]       = s_q.overcurrent_setting[i][OCR_XENON];
      s_d.retry[i]       = !s_q.conf1[i][CONF1_RTY_DIS];
    end
    s_d.ov_prot  = !s_q.global_config[GCR_OV_DIS];
    s_d.vdd_fail = s_q.global_config[GCR_VDD_FAIL];
  end

  // ****************************************
  // system clock registers
  // ****************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q          <= '0;
      s_q.sel      <= SEL_RESET;
      s_q.por      <= POR_RESET;
      s_q.cs_prev  <= 1'b1;
      s_q.fault_n  <= 1'b1;
      s_q.pwm      <= {4{PWM_RESET}};
      s_q.conf0    <= {4{CONF0_RESET}};
      s_q.conf1    <= {4{CONF1_RESET}};
      s_q.overcurrent_setting      <= {4{OCR_RESET}};
      s_q.global_config      <= GCR_RESET;
      s_q.slew     <= 8'h55;
      s_q.xenon    <= 4'hf;
      s_q.retry    <= 4'hf;
      s_q.ov_prot  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // link clock next state
  // ****************************************
  always_comb begin
    l_d       = l_q;
    l_d.rx    = {l_q.rx[14:0], i_si};
    l_d.valid = (edge_cnt[3:0] == EDGE_LAST);
    l_d.tx    = {l_q.tx[14:0], 1'b0};
    // marks that this frame saw at least one edge
    if (!edge_cnt[4] && (edge_cnt[3:0] == EDGE_HEADER)) begin
      l_d.frame_tog = !l_q.frame_tog;
    end
    if (edge_cnt[3:0] == EDGE_LAST) begin
      // first bit of the next frame is this frame's watchdog bit
      l_d.tx = {l_q.rx[14], 15'h0000};
    end else if (!edge_cnt[4] && (edge_cnt[3:0] == EDGE_HEADER)) begin
      l_d.tx = {s_q.resp, 1'b0};
    end else if (!edge_cnt[4] && (edge_cnt[3:0] == EDGE_FIELD)) begin
      // readback loaded late so the frozen copy has settled
      l_d.tx = {s_q.resp[8:0], 7'h00};
    end
  end

  // ****************************************
  // link clock registers
  // ****************************************
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_so                  = l_q.tx[15];
  assign o_so_oe               = s_q.so_oe;
  assign o_fault_status_pin_n  = s_q.fault_n;
  assign o_high_side_output    = s_q.hs;
  assign o_slew_rate           = s_q.slew;
  assign o_xenon_profile       = s_q.xenon;
  assign o_retry_enable        = s_q.retry;
  assign o_overvoltage_protect = s_q.ov_prot;
  assign o_vdd_fail_detect     = s_q.vdd_fail;

  // ****************************************
  // checks
  // ****************************************
  a_por_sticky: assert property (@(posedge i_clk) disable iff (i_reset)
    s_q.por && !(accept && (s_q.sel[2:0] == KIND_STATUS)) |=> s_q.por)
    else $error("power-on flag lost without a read");
  a_por_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    accept && (s_q.sel[2:0] == KIND_STATUS) && !i_por_event |=> !s_q.por)
    else $error("power-on flag not cleared by read");
  a_fault_field: assert property (@(posedge i_clk) disable iff (i_reset)
    cs_s && (s_q.sel[2:0] == KIND_STATUS) |=> s_q.resp[7:0] == $past(fault_word[7:0]))
    else $error("fault field wrong");
  a_fault_pin: assert property (@(posedge i_clk) disable iff (i_reset)
    (|i_overcurrent_flag) || i_undervoltage_flag |=> !o_fault_status_pin_n)
    else $error("fault pin not asserted");
  a_latch_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    (|s_q.latch) && (i_fault_control == s_q.ctl_prev) |=> !o_fault_status_pin_n)
    else $error("latched fault released without toggle");
  a_global_field: assert property (@(posedge i_clk) disable iff (i_reset)
    cs_s && (s_q.sel == SEL_GLOBAL) |=> s_q.resp[8:0] == $past(s_q.global_config))
    else $error("global readback wrong");
  a_input_word: assert property (@(posedge i_clk) disable iff (i_reset)
    cs_s && (s_q.sel == SEL_IN_WD) && i_failsafe |=> s_q.resp[4:1] == $past(i_failsafe_outputs))
    else $error("fail-safe states not reported");
  a_product_code: assert property (@(posedge i_clk) disable iff (i_reset)
    cs_s && (s_q.sel == SEL_PRODUCT) |=> s_q.resp[8:0] == {6'h00, PRODUCT_ID})
    else $error("product code wrong");
  a_header_echo: assert property (@(posedge i_clk) disable iff (i_reset)
    cs_s |=> s_q.resp[14:9] == {$past(s_q.sel), $past(i_normal_mode_flag)})
    else $error("header echo wrong");
  a_select_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    !accept |=> $stable(s_q.sel))
    else $error("selection changed without a write");
  a_unlisted_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    cs_s && (s_q.sel[2:0] == 3'h7) && (s_q.sel != SEL_CLK_TEMP) && (s_q.sel != SEL_IN_WD)
      && (s_q.sel != SEL_PRODUCT) |=> s_q.resp[8:0] == 9'h000)
    else $error("unlisted code not zero");
  a_link_header: assert property (@(posedge i_sclk) disable iff (i_reset || i_cs_n)
    !edge_cnt[4] && (edge_cnt[3:0] == EDGE_HEADER) |=> o_so == $past(s_q.resp[14]))
    else $error("header not loaded at frame start");

  c_status_read: cover property (@(posedge i_clk) disable iff (i_reset)
    accept && (s_q.sel[2:0] == KIND_STATUS));
  c_select_write: cover property (@(posedge i_clk) disable iff (i_reset)
    accept && (cmd[2:0] == KIND_STATUS) && (data[4:0] == SEL_IN_WD));
  c_latch_release: cover property (@(posedge i_clk) disable iff (i_reset)
    (|s_q.latch) ##1 !(|s_q.latch));
  c_full_frame: cover property (@(posedge i_sclk) disable iff (i_reset || i_cs_n)
    edge_cnt[3:0] == EDGE_LAST);
endmodule // spi_status_readback_mux

/* File: spi_host_model.sv */
// ****************************************
// host side of the serial link: one frame per call
// ****************************************
module spi_host_model (
  output logic      o_sclk,   // link clock, idle low, still between frames
  output logic      o_cs_n,   // frame select, active low
  output logic      o_si,     // serial data towards the device
  input  wire logic i_so,     // serial data from the device
  input  wire logic i_so_oe   // device drive enable
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // 32 ns link period; host changes data after falling edges and samples on them
  task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
    int i;
    r = '0;
    #7;
    o_cs_n = 1'b0;
    #200;
    // a released output reads as z so a missing drive cannot match
    r[15] = i_so_oe ? i_so : 1'bz;
    for (i = 15; i > 15 - nb; i--) begin
      o_si = w[i];
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
      if (i > 0) begin
        r[i-1] = i_so;
      end
    end
    #16 o_cs_n = 1'b1;
    // released line shows the inverse of the last bit
    o_si = ~o_si;
  endtask
endmodule // spi_host_model

/* File: tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import readback_pkg::*;

  // ****************************************
  // design pins and reference model state
  // ****************************************
  logic i_clk, i_reset, i_sclk, i_cs_n, i_si, o_so, o_so_oe, o_fault_status_pin_n;
  logic i_normal_mode_flag, i_por_event, i_overvoltage_flag, i_undervoltage_flag, i_fault_control;
  logic i_pwm_clock_fail, i_cal_fail, i_overtemp_prewarning, i_watchdog_enabled_flag, i_failsafe;
  logic [3:0] i_direct_in, i_overcurrent_flag, i_severe_short_flag, i_short_to_supply_flag;
  logic [3:0] i_openload_off_flag, i_openload_on_flag, i_overtemp_flag, i_failsafe_outputs;
  logic [3:0] o_high_side_output, o_xenon_profile, o_retry_enable;
  logic [7:0] o_slew_rate;
  logic       o_overvoltage_protect, o_vdd_fail_detect;
  logic [8:0] pwm_m [4], conf0_m [4], conf1_m [4], ocr_m [4], gcr_m;  // stored settings
  logic [4:0] sel_m;                                                 // active select
  logic       por_m, wd_m, latch_m;                                  // flags
  logic [31:0] seed = 32'h229779d9;
  logic [4:0] codes [11] = '{5'h00, 5'h09, 5'h12, 5'h1b, 5'h04, 5'h05, 5'h07, 5'h0f, 5'h17, 5'h06, 5'h1f};
  int         n_errors = 0, num_checks = 0, cyc = 0;

  spi_status_readback_mux spi_status_readback_mux_i (.i_clk, .i_reset, .i_sclk, .i_cs_n, .i_si, .o_so, .o_so_oe,
    .i_direct_in, .i_normal_mode_flag, .i_por_event, .i_overcurrent_flag, .i_severe_short_flag,
    .i_short_to_supply_flag, .i_openload_off_flag, .i_openload_on_flag, .i_overtemp_flag, .i_overvoltage_flag,
    .i_undervoltage_flag, .i_fault_control, .i_pwm_clock_fail, .i_cal_fail, .i_overtemp_prewarning,
    .i_watchdog_enabled_flag, .i_failsafe, .i_failsafe_outputs, .o_fault_status_pin_n, .o_high_side_output,
    .o_slew_rate, .o_xenon_profile, .o_retry_enable, .o_overvoltage_protect, .o_vdd_fail_detect);
  spi_host_model spi_host_model_i (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so), .i_so_oe(o_so_oe));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // hang guard: about fifteen times the expected run
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [8:0] field_m(input logic [4:0] s);
    logic [1:0] a = s[4:3];
    case (s[2:0])
      KIND_STATUS: return {por_m, i_undervoltage_flag, i_overvoltage_flag, i_openload_on_flag[a],
        i_openload_off_flag[a], i_short_to_supply_flag[a], i_overtemp_flag[a], i_severe_short_flag[a],
        i_overcurrent_flag[a]};
      KIND_PWM:    return pwm_m[a];
      KIND_CONF0:  return conf0_m[a];
      KIND_CONF1:  return conf1_m[a];
      KIND_OCR:    return ocr_m[a];
      default:     ;
    endcase
    case (s)
      SEL_GLOBAL:   return gcr_m;
      SEL_CLK_TEMP: return {6'h0, i_pwm_clock_fail, i_cal_fail, i_overtemp_prewarning};
      SEL_IN_WD:    return {4'h0, i_failsafe ? i_failsafe_outputs : i_direct_in, i_watchdog_enabled_flag};
      SEL_PRODUCT:  return {6'h0, PRODUCT_ID};
      default:      return 9'h000;   // unlisted codes read zero
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask

  // expected pin levels from stored settings and live inputs
  task automatic chk_pins();
    logic [3:0] hs, xe, rt;
    logic [7:0] sr;
    logic       flt;
    for (int i = 0; i < 4; i++) begin
      hs[i] = i_failsafe ? i_failsafe_outputs[i] : conf0_m[i][CONF0_DIR_DIS] ? pwm_m[i][PWM_ON_POS]
        : i_direct_in[i] | pwm_m[i][PWM_ON_POS];
      sr[2*i+:2] = conf0_m[i][CONF0_SR_LO+:2];
      xe[i] = ocr_m[i][OCR_XENON];
      rt[i] = !conf1_m[i][CONF1_RTY_DIS];
    end
    flt = latch_m | (|i_openload_on_flag) | (|i_openload_off_flag) | (|i_short_to_supply_flag);
    flt = flt | i_overvoltage_flag | i_undervoltage_flag;
    chk("pins", {o_fault_status_pin_n, o_high_side_output, o_slew_rate, o_xenon_profile, o_retry_enable,
      o_overvoltage_protect, o_vdd_fail_detect}, {!flt, hs, sr, xe, rt, !gcr_m[GCR_OV_DIS], gcr_m[GCR_VDD_FAIL]});
  endtask

  // one frame; stored settings, select and power-on flag updated only for whole 16-bit frames
  task automatic frame(input logic [15:0] w, input int nb);
    logic [15:0] r, e;
    e = {wd_m, sel_m, i_normal_mode_flag, field_m(sel_m)};
    spi_host_model_i.xfer(w, nb, r);
    if (nb == 16) begin
      chk("response", r, e);
      por_m = (sel_m[2:0] == KIND_STATUS) ? 1'b0 : por_m;
      wd_m = w[15];
      if (w[14:10] == SEL_GLOBAL) gcr_m = w[8:0] & GCR_MASK;
      else case (w[12:10])
        KIND_STATUS: sel_m = w[4:0];
        KIND_PWM:    pwm_m[w[14:13]] = w[8:0] & PWM_MASK;
        KIND_CONF0:  conf0_m[w[14:13]] = w[8:0] & CONF0_MASK;
        KIND_CONF1:  conf1_m[w[14:13]] = w[8:0] & CONF1_MASK;
        KIND_OCR:    ocr_m[w[14:13]] = w[8:0] & OCR_MASK;
        default:     ;
      endcase
    end else begin
      // a cut frame leaves its last shifted bit, or the old header bit, on the link
      wd_m = e[15 - nb];
    end
    repeat (10) @(posedge i_clk);
    chk_pins();
  endtask

  task automatic rand_in();
    @(posedge i_clk);
    seed = lfsr(seed);
    {i_openload_on_flag, i_openload_off_flag, i_short_to_supply_flag, i_direct_in, i_failsafe_outputs,
      i_overvoltage_flag, i_undervoltage_flag, i_normal_mode_flag, i_pwm_clock_fail, i_cal_fail,
      i_overtemp_prewarning, i_watchdog_enabled_flag, i_failsafe} <= seed[27:0];
    repeat (6) @(posedge i_clk);
  endtask

  task automatic results();
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_reset = 1'b1;
    {i_normal_mode_flag, i_por_event, i_overvoltage_flag, i_undervoltage_flag, i_fault_control} = '0;
    {i_pwm_clock_fail, i_cal_fail, i_overtemp_prewarning, i_watchdog_enabled_flag, i_failsafe} = '0;
    {i_direct_in, i_overcurrent_flag, i_severe_short_flag, i_short_to_supply_flag} = '0;
    {i_openload_off_flag, i_openload_on_flag, i_overtemp_flag, i_failsafe_outputs} = '0;
    for (int i = 0; i < 4; i++) begin
      {pwm_m[i], conf0_m[i], conf1_m[i], ocr_m[i]} = {PWM_RESET, CONF0_RESET, CONF1_RESET, OCR_RESET};
    end
    {gcr_m, sel_m, por_m, wd_m, latch_m} = {GCR_RESET, SEL_RESET, POR_RESET, 2'b00};
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk_pins();
    frame(16'h0000, 16);
    // latched fault holds the pin until the control toggles
    @(posedge i_clk);
    i_overcurrent_flag <= 4'h2;
    latch_m = 1'b1;
    repeat (3) @(posedge i_clk);
    chk_pins();
    i_overcurrent_flag <= 4'h0;
    repeat (3) @(posedge i_clk);
    chk_pins();
    i_fault_control <= 1'b1;
    latch_m = 1'b0;
    repeat (3) @(posedge i_clk);
    chk_pins();
    // each of the 11 select codes, 9 listed and 2 unlisted, twice, each followed by a random settings write
    for (int k = 0; k < 2; k++) begin
      foreach (codes[c]) begin
        rand_in();
        frame({seed[31], seed[1:0], KIND_STATUS, 5'h00, codes[c]}, 16);
        seed = lfsr(seed);
        frame(seed[2:0] > 3'h3 ? {seed[31], SEL_GLOBAL, 1'b0, seed[16:8]}
          : {seed[31], seed[4:3], seed[2:0] + 3'h1, 1'b0, seed[16:8]}, 16);
      end
    end
    // new power-on event survives refused empty and short frames
    frame(16'h0000, 16);
    @(posedge i_clk);
    i_por_event <= 1'b1;
    @(posedge i_clk);
    i_por_event <= 1'b0;
    por_m = 1'b1;
    frame(16'h0000, 0);
    frame(16'h0000, 8);
    frame(16'h0000, 16);
    results();
  end
endmodule // tb_top
